// ==== rtl/odct_pkg.sv ====
package odct_pkg;

  localparam int INSN_W      = 14;
  localparam int DATA_W      = 8;
  localparam int FADDR_W     = 7;
  localparam int BITSEL_W    = 3;
  localparam int LIT8_W      = 8;
  localparam int LIT11_W     = 11;
  localparam int PHASES      = 4;

  // Opcode field positions
  localparam int CLASS_HI    = 13;
  localparam int CLASS_LO    = 12;
  localparam int DEST_POS    = 7;
  localparam int BYTEOP_HI   = 11;
  localparam int BYTEOP_LO   = 8;
  localparam int BITOP_HI    = 11;
  localparam int BITOP_LO    = 10;
  localparam int BIT_HI      = 9;
  localparam int BIT_LO      = 7;
  localparam int CTRL_POS    = 11;
  localparam int LITOP_HI    = 11;
  localparam int LITOP_LO    = 8;

  localparam logic [1:0] CLASS_BYTE = 2'h0;
  localparam logic [1:0] CLASS_BIT  = 2'h1;
  localparam logic [1:0] CLASS_JUMP = 2'h2;
  localparam logic [1:0] CLASS_LIT  = 2'h3;

  // Byte-oriented operations
  localparam logic [3:0] BOP_MISC  = 4'h0;
  localparam logic [3:0] BOP_CLR   = 4'h1;
  localparam logic [3:0] BOP_SUB   = 4'h2;
  localparam logic [3:0] BOP_DEC   = 4'h3;
  localparam logic [3:0] BOP_IOR   = 4'h4;
  localparam logic [3:0] BOP_AND   = 4'h5;
  localparam logic [3:0] BOP_XOR   = 4'h6;
  localparam logic [3:0] BOP_ADD   = 4'h7;
  localparam logic [3:0] BOP_MOV   = 4'h8;
  localparam logic [3:0] BOP_COM   = 4'h9;
  localparam logic [3:0] BOP_INC   = 4'ha;
  localparam logic [3:0] BOP_DECSZ = 4'hb;
  localparam logic [3:0] BOP_RRF   = 4'hc;
  localparam logic [3:0] BOP_RLF   = 4'hd;
  localparam logic [3:0] BOP_SWAP  = 4'he;
  localparam logic [3:0] BOP_INCSZ = 4'hf;

  // Bit-oriented operations
  localparam logic [1:0] BIT_CLR  = 2'h0;
  localparam logic [1:0] BIT_SET  = 2'h1;
  localparam logic [1:0] BIT_TSTC = 2'h2;
  localparam logic [1:0] BIT_TSTS = 2'h3;

  // Literal operations, upper nibble with ignored low bits masked
  localparam logic [3:0] LOP_MOVL = 4'h0;
  localparam logic [3:0] LOP_RETL = 4'h4;
  localparam logic [3:0] LOP_IORL = 4'h8;
  localparam logic [3:0] LOP_ANDL = 4'h9;
  localparam logic [3:0] LOP_XORL = 4'ha;
  localparam logic [3:0] LOP_SUBL = 4'hc;
  localparam logic [3:0] LOP_ADDL = 4'he;

  localparam logic [INSN_W-1:0] NOP_WORD = 14'h0000;

  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic [FADDR_W-1:0] FIRST_PORT_ADDR = 7'h05;

  typedef enum logic [3:0] {
    ODCT_Q1 = 4'b0001,
    ODCT_Q2 = 4'b0010,
    ODCT_Q3 = 4'b0100,
    ODCT_Q4 = 4'b1000
  } odct_phase_t;

endpackage

// ==== rtl/odct_field_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module odct_field_decode
  import odct_pkg::*;
(
  input  wire logic [INSN_W-1:0]   insn_i,
  output logic      [1:0]          class_o,
  output logic                     dest_file_o,
  output logic      [FADDR_W-1:0]  faddr_o,
  output logic      [BITSEL_W-1:0] bitsel_o,
  output logic      [LIT8_W-1:0]   lit8_o,
  output logic      [LIT11_W-1:0]  lit11_o,
  output logic      [3:0]          byteop_o,
  output logic      [1:0]          bitop_o,
  output logic      [3:0]          litop_o,
  output logic                     is_goto_o
);

  assign class_o     = insn_i[CLASS_HI:CLASS_LO];
  assign dest_file_o = insn_i[DEST_POS];
  assign faddr_o     = insn_i[FADDR_W-1:0];
  assign bitsel_o    = insn_i[BIT_HI:BIT_LO];
  assign lit8_o      = insn_i[LIT8_W-1:0];
  assign lit11_o     = insn_i[LIT11_W-1:0];
  assign byteop_o    = insn_i[BYTEOP_HI:BYTEOP_LO];
  assign bitop_o     = insn_i[BITOP_HI:BITOP_LO];
  assign is_goto_o   = insn_i[CTRL_POS];

  // Don't-care bits in the literal group are forced low
  always_comb
  begin
    litop_o = insn_i[LITOP_HI:LITOP_LO];
    if (litop_o[3:2] == 2'h0)
      litop_o = LOP_MOVL;
    else if (litop_o[3:2] == 2'h1)
      litop_o = LOP_RETL;
    else if (litop_o[3:1] == 3'h6)
      litop_o = LOP_SUBL;
    else if (litop_o[3:1] == 3'h7)
      litop_o = LOP_ADDL;
  end

endmodule
`default_nettype wire

// ==== rtl/odct_core.sv ====
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module odct_core
  import odct_pkg::*;
#(
  parameter int PC_W = LIT11_W
)
(
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                clk_en_i,
  input  wire logic [INSN_W-1:0]   insn_i,
  input  wire logic [DATA_W-1:0]   file_rdata_i,
  output logic      [PC_W-1:0]     pc_o,
  output logic      [FADDR_W-1:0]  file_addr_o,
  output logic                     file_rd_o,
  output logic                     file_wr_o,
  output logic      [DATA_W-1:0]   file_wdata_o,
  output logic      [DATA_W-1:0]   acc_o,
  output logic                     first_port_read_o,
  output logic      [3:0]          phase_o,
  output logic                     cycle_start_o,
  output logic                     flush_o
);

  logic [1:0]          ins_class;
  logic                dest_file;
  logic [FADDR_W-1:0]  faddr;
  logic [BITSEL_W-1:0] bitsel;
  logic [LIT8_W-1:0]   lit8;
  logic [LIT11_W-1:0]  lit11;
  logic [3:0]          byteop;
  logic [1:0]          bitop;
  logic [3:0]          litop;
  logic                is_goto;
  logic [INSN_W-1:0]   insn_reg;

  odct_field_decode u_dec (
    .insn_i      (insn_reg),
    .class_o     (ins_class),
    .dest_file_o (dest_file),
    .faddr_o     (faddr),
    .bitsel_o    (bitsel),
    .lit8_o      (lit8),
    .lit11_o     (lit11),
    .byteop_o    (byteop),
    .bitop_o     (bitop),
    .litop_o     (litop),
    .is_goto_o   (is_goto)
  );

  odct_phase_t         phase_reg;
  logic [DATA_W-1:0]   operand_reg;
  logic [DATA_W-1:0]   result_next;
  logic                to_file;
  logic                uses_file;
  logic                writes_back;
  logic                take_branch;
  logic                skip_cond;
  logic                flush_reg;
  logic [PC_W-1:0]     pc_reg;
  logic [DATA_W-1:0]   acc_reg;
  logic [DATA_W-1:0]   bitmask;
  logic                zero_res;

  // Phase sequencer: four clock periods per instruction cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      phase_reg <= ODCT_Q1;
    else if (clk_en_i)
    begin
      unique case (phase_reg)
        ODCT_Q1: phase_reg <= ODCT_Q2;
        ODCT_Q2: phase_reg <= ODCT_Q3;
        ODCT_Q3: phase_reg <= ODCT_Q4;
        ODCT_Q4: phase_reg <= ODCT_Q1;
        default: phase_reg <= ODCT_Q1;
      endcase
    end
  end

  // Latch the fetched word at Q1; a flushed cycle runs as a no-operation
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      insn_reg <= NOP_WORD;
    else if (clk_en_i && phase_reg == ODCT_Q1)
      insn_reg <= flush_reg ? NOP_WORD : insn_i;
  end

  assign bitmask  = DATA_W'(1) << bitsel;
  assign zero_res = (result_next == '0);

  // Which instructions touch the register file
  always_comb
  begin
    uses_file   = 1'b0;
    writes_back = 1'b0;
    to_file     = 1'b0;
    unique case (ins_class)
      CLASS_BYTE:
      begin
        if (byteop == BOP_MISC)
        begin
          uses_file   = dest_file;
          writes_back = dest_file;
          to_file     = dest_file;
        end
        else
        begin
          uses_file   = 1'b1;
          writes_back = 1'b1;
          to_file     = dest_file;
        end
        if (byteop == BOP_CLR && !dest_file)
          uses_file = 1'b0;
      end
      CLASS_BIT:
      begin
        uses_file   = 1'b1;
        writes_back = (bitop == BIT_CLR) || (bitop == BIT_SET);
        to_file     = writes_back;
      end
      default:
      begin
        uses_file   = 1'b0;
        writes_back = 1'b0;
        to_file     = 1'b0;
      end
    endcase
  end

  // Datapath: modify the operand read at Q2
  always_comb
  begin
    result_next = operand_reg;
    unique case (ins_class)
      CLASS_BYTE:
      begin
        unique case (byteop)
          BOP_MISC:  result_next = acc_reg;
          BOP_CLR:   result_next = '0;
          BOP_SUB:   result_next = operand_reg - acc_reg;
          BOP_DEC:   result_next = operand_reg - DATA_W'(1);
          BOP_IOR:   result_next = operand_reg | acc_reg;
          BOP_AND:   result_next = operand_reg & acc_reg;
          BOP_XOR:   result_next = operand_reg ^ acc_reg;
          BOP_ADD:   result_next = operand_reg + acc_reg;
          BOP_MOV:   result_next = operand_reg;
          BOP_COM:   result_next = ~operand_reg;
          BOP_INC:   result_next = operand_reg + DATA_W'(1);
          BOP_DECSZ: result_next = operand_reg - DATA_W'(1);
          BOP_RRF:   result_next = {1'b0, operand_reg[DATA_W-1:1]};
          BOP_RLF:   result_next = {operand_reg[DATA_W-2:0], 1'b0};
          BOP_SWAP:  result_next = {operand_reg[3:0], operand_reg[7:4]};
          BOP_INCSZ: result_next = operand_reg + DATA_W'(1);
        endcase
      end
      CLASS_BIT:
      begin
        if (bitop == BIT_CLR)
          result_next = operand_reg & ~bitmask;
        else
          result_next = operand_reg | bitmask;
      end
      CLASS_JUMP:
        result_next = acc_reg;
      CLASS_LIT:
      begin
        unique case (litop)
          LOP_IORL: result_next = acc_reg | lit8;
          LOP_ANDL: result_next = acc_reg & lit8;
          LOP_XORL: result_next = acc_reg ^ lit8;
          LOP_SUBL: result_next = lit8 - acc_reg;
          LOP_ADDL: result_next = lit8 + acc_reg;
          default:  result_next = lit8;
        endcase
      end
    endcase
  end

  // Taken skips and jumps cost a second, empty instruction cycle
  always_comb
  begin
    skip_cond = 1'b0;
    if (ins_class == CLASS_BYTE && (byteop == BOP_DECSZ || byteop == BOP_INCSZ))
      skip_cond = zero_res;
    else if (ins_class == CLASS_BIT && bitop == BIT_TSTC)
      skip_cond = ((operand_reg & bitmask) == '0);
    else if (ins_class == CLASS_BIT && bitop == BIT_TSTS)
      skip_cond = ((operand_reg & bitmask) != '0);
    take_branch = skip_cond || ins_class == CLASS_JUMP;
  end

  // Operand read at Q2, even when the instruction only writes
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      operand_reg <= '0;
    else if (clk_en_i && phase_reg == ODCT_Q2 && uses_file)
      operand_reg <= file_rdata_i;
  end

  // Register file strobes: read in Q2->Q3, write in Q3->Q4
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      file_addr_o       <= '0;
      file_rd_o         <= 1'b0;
      file_wr_o         <= 1'b0;
      file_wdata_o      <= '0;
      first_port_read_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      file_rd_o         <= 1'b0;
      file_wr_o         <= 1'b0;
      first_port_read_o <= 1'b0;
      if (phase_reg == ODCT_Q1 && !flush_reg)
      begin
        file_addr_o <= insn_i[FADDR_W-1:0];
      end
      if (phase_reg == ODCT_Q2 && uses_file)
      begin
        file_rd_o         <= 1'b1;
        first_port_read_o <= (faddr == FIRST_PORT_ADDR);
      end
      if (phase_reg == ODCT_Q3 && writes_back && to_file)
      begin
        file_wr_o    <= 1'b1;
        file_wdata_o <= result_next;
      end
    end
  end

  // Accumulator update at end of cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      acc_reg <= ACC_RST;
    else if (clk_en_i && phase_reg == ODCT_Q4)
    begin
      if (ins_class == CLASS_BYTE && byteop != BOP_MISC && !dest_file)
        acc_reg <= result_next;
      else if (ins_class == CLASS_LIT)
        acc_reg <= result_next;
    end
  end

  // Program counter and flush of the prefetched word
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pc_reg    <= '0;
      flush_reg <= 1'b0;
    end
    else if (clk_en_i && phase_reg == ODCT_Q4)
    begin
      if (ins_class == CLASS_JUMP)
        pc_reg <= PC_W'(lit11);
      else
        pc_reg <= pc_reg + PC_W'(1);
      flush_reg <= take_branch;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pc_o          <= '0;
      acc_o         <= ACC_RST;
      phase_o       <= ODCT_Q1;
      cycle_start_o <= 1'b0;
      flush_o       <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pc_o          <= pc_reg;
      acc_o         <= acc_reg;
      phase_o       <= phase_reg;
      cycle_start_o <= (phase_reg == ODCT_Q4);
      flush_o       <= flush_reg;
    end
  end

endmodule
`default_nettype wire

// ==== bench/odct_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module odct_chk
  import odct_pkg::*;
(
  input wire logic               ref_clk_i,
  input wire logic               rst_n_i,
  input wire logic               clk_en_i,
  input wire logic [FADDR_W-1:0] file_addr_o,
  input wire logic               file_rd_o,
  input wire logic               file_wr_o,
  input wire logic               first_port_read_o,
  input wire logic [3:0]         phase_o,
  input wire logic               cycle_start_o,
  input wire logic               flush_o
);
  // Last phase seen, so a skipped step shows
  logic [3:0] ph_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
      ph_reg <= ODCT_Q1;
    else
      ph_reg <= phase_o;

  // Frozen clocks are not counted, so a held enable cannot stretch a cycle
  default clocking cb @(posedge ref_clk_i iff clk_en_i);
  endclocking
  default disable iff (!rst_n_i);

  phase_hot_a: assert property ($onehot(phase_o))
    else $error("phase not one-hot");
  phase_step_a: assert property (phase_o != ph_reg |-> phase_o == {ph_reg[2:0], ph_reg[3]})
    else $error("phase skipped a step");
  cycle_len_a: assert property (cycle_start_o |=> !cycle_start_o [*3] ##1 cycle_start_o)
    else $error("cycle not four clocks");
  rd_once_a: assert property (file_rd_o |=> !file_rd_o [*3])
    else $error("two reads in one cycle");
  read_first_a: assert property (file_wr_o |-> $past(file_rd_o))
    else $error("store without read");
  addr_hold_a: assert property (file_wr_o |-> $stable(file_addr_o))
    else $error("address moved before store");
  port_read_a: assert property (first_port_read_o == (file_rd_o && file_addr_o == FIRST_PORT_ADDR))
    else $error("port read flag wrong");
  flush_quiet_a: assert property (flush_o |-> !file_rd_o && !file_wr_o)
    else $error("access in no-op cycle");
  flush_len_a: assert property ($rose(flush_o) |-> flush_o [*4] ##1 !flush_o)
    else $error("no-op cycle length wrong");

  port_read_c: cover property (first_port_read_o);
  flush_c: cover property ($rose(flush_o));
  store_c: cover property (file_wr_o);
endmodule
`default_nettype wire

// ==== bench/odct_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module odct_core_tb
  import odct_pkg::*;
;
  logic               ref_clk_i = 1'b0;
  logic               rst_n_i = 1'b0;
  logic               clk_en = 1'b1;
  logic [INSN_W-1:0]  insn = NOP_WORD;
  logic [DATA_W-1:0]  rdata;
  logic [DATA_W-1:0]  wdata;
  logic [DATA_W-1:0]  acc;
  logic [FADDR_W-1:0] addr;
  logic [LIT11_W-1:0] pc;
  logic [3:0]         phase;
  logic               rd;
  logic               wr;
  logic               port_rd;
  logic               cyc;
  logic               flush;
  logic [7:0]         rf [128] = '{default: 8'h00};
  logic [3:0]         lop [4] = '{LOP_IORL, LOP_ANDL, LOP_XORL, LOP_ADDL};
  logic [7:0]         lk [4] = '{8'h0f, 8'h3c, 8'hff, 8'h01};
  logic [7:0]         lx [4] = '{8'h5f, 8'h1c, 8'he3, 8'he4};
  int                 err_total = 0;
  int                 checks = 0;
  int                 port_cnt = 0;
  int                 flush_cnt = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  odct_core i_odct_core (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en), .insn_i(insn),
    .file_rdata_i(rdata), .pc_o(pc), .file_addr_o(addr), .file_rd_o(rd), .file_wr_o(wr),
    .file_wdata_o(wdata), .acc_o(acc), .first_port_read_o(port_rd), .phase_o(phase),
    .cycle_start_o(cyc), .flush_o(flush)
  );

  // Register file answers at once; the core samples it later
  assign rdata = rf[addr];

  always @(posedge ref_clk_i)
  begin
    if (wr)
      rf[addr] <= wdata;
    if (port_rd)
      port_cnt <= port_cnt + 1;
    if (flush)
      flush_cnt <= flush_cnt + 1;
  end

  // Word held for a whole cycle, so the taking edge never races
  task automatic run(input logic [INSN_W-1:0] w);
    insn <= w;
    repeat (4) @(posedge ref_clk_i);
  endtask

  // Trailing no-op lets stores and accumulator land first
  task automatic exe(input logic [INSN_W-1:0] w);
    run(w);
    run(NOP_WORD);
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    exe({CLASS_LIT, 4'h3, 8'h5a});
    chk("acc", 8'h5a, acc);
    foreach (lop[i])
    begin
      exe({CLASS_LIT, lop[i], lk[i]});
      chk("acc", lx[i], acc);
    end
    exe({CLASS_BYTE, BOP_MISC, 1'b0, 7'h60});
    chk("acc", 8'he4, acc);
    chk("file 60", 8'h00, rf[7'h60]);
    exe({CLASS_BYTE, BOP_MISC, 1'b1, 7'h7f});
    chk("file 7f", 8'he4, rf[7'h7f]);
    rf[7'h20] = 8'h11;
    exe({CLASS_BYTE, BOP_ADD, 1'b0, 7'h20});
    chk("acc", 8'hf5, acc);
    chk("file 20", 8'h11, rf[7'h20]);
    exe({CLASS_BYTE, BOP_ADD, 1'b1, 7'h20});
    chk("file 20", 8'h06, rf[7'h20]);
    chk("acc", 8'hf5, acc);
    for (int b = 0; b < 8; b++)
    begin
      exe({CLASS_BIT, BIT_SET, 3'(b), 7'h21});
      chk("file 21", 8'((2 << b) - 1), rf[7'h21]);
    end
    exe({CLASS_BIT, BIT_CLR, 3'h3, 7'h21});
    chk("file 21", 8'hf7, rf[7'h21]);
    rf[FIRST_PORT_ADDR] = 8'h3c;
    exe({CLASS_BYTE, BOP_CLR, 1'b1, FIRST_PORT_ADDR});
    chk("port", 8'h00, rf[FIRST_PORT_ADDR]);
    chk("port reads", 8'h01, 8'(port_cnt));
    exe({CLASS_BYTE, BOP_CLR, 1'b1, 7'h06});
    exe({CLASS_BYTE, BOP_CLR, 1'b0, FIRST_PORT_ADDR});
    chk("acc", 8'h00, acc);
    chk("port reads", 8'h01, 8'(port_cnt));
    exe({CLASS_LIT, LOP_MOVL, 8'h33});
    run({CLASS_JUMP, 1'b0, 11'h123});
    exe({CLASS_LIT, LOP_MOVL, 8'h77});
    chk("acc", 8'h33, acc);
    chk("flush clocks", 8'h04, 8'(flush_cnt));
    rf[7'h30] = 8'h02;
    run({CLASS_BYTE, BOP_DECSZ, 1'b1, 7'h30});
    exe({CLASS_LIT, LOP_MOVL, 8'h44});
    chk("acc", 8'h44, acc);
    chk("flush clocks", 8'h04, 8'(flush_cnt));
    run({CLASS_BYTE, BOP_DECSZ, 1'b1, 7'h30});
    exe({CLASS_LIT, LOP_MOVL, 8'h55});
    chk("acc", 8'h44, acc);
    chk("file 30", 8'h00, rf[7'h30]);
    run({CLASS_BIT, BIT_TSTC, 3'h3, 7'h21});
    exe({CLASS_LIT, LOP_MOVL, 8'h66});
    chk("acc", 8'h44, acc);
    chk("flush clocks", 8'h0c, 8'(flush_cnt));
    insn <= {CLASS_LIT, LOP_MOVL, 8'h99};
    @(posedge ref_clk_i);
    clk_en <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    chk("acc", 8'h44, acc);
    chk("phase", 8'h01, {4'h0, phase});
    clk_en <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    run(NOP_WORD);
    chk("acc", 8'h99, acc);
    rst_n_i <= 1'b0;
    @(posedge ref_clk_i);
    chk("acc", 8'h00, acc);
    chk("pc", 8'h00, pc[7:0]);
    chk("phase", 8'h01, {4'h0, phase});
    rst_n_i <= 1'b1;
    exe({CLASS_LIT, LOP_MOVL, 8'h12});
    chk("acc", 8'h12, acc);
    chk("pc", 8'h01, pc[7:0]);
    wrap_up();
  end

  initial
  begin
    #20000;
    err_total++;
    $display("unexpected run: expected end seen timeout");
    wrap_up();
  end
endmodule

bind odct_core odct_chk i_odct_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .file_addr_o(file_addr_o), .file_rd_o(file_rd_o),
  .file_wr_o(file_wr_o), .first_port_read_o(first_port_read_o), .phase_o(phase_o),
  .cycle_start_o(cycle_start_o), .flush_o(flush_o)
);
`default_nettype wire
